// File: hw/pwm_scaler_pkg.sv
package pwm_scaler_pkg;

  // Register addresses on the plain register port.
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 8;
  localparam logic [3:0]  ADDR_CONTROL     = 4'h0;
  localparam logic [3:0]  ADDR_COUNTER     = 4'h1;
  localparam logic [3:0]  ADDR_PERIOD      = 4'h2;
  localparam logic [3:0]  ADDR_DUTY        = 4'h3;
  localparam logic [3:0]  ADDR_FACTORY     = 4'h7;
  localparam logic [3:0]  ADDR_SCALE_A     = 4'h8;

  // Control register field positions.
  localparam int unsigned CTL_ENABLE_BIT   = 0;
  localparam int unsigned CTL_POLARITY_BIT = 1;
  localparam int unsigned CTL_CLKSEL_BIT   = 2;

  // Reset values, and the value the factory test address reads.
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  PERIOD_RESET     = 8'h00;
  localparam logic [7:0]  DUTY_RESET       = 8'h00;
  localparam logic [7:0]  SCALE_RESET      = 8'h00;
  localparam logic [7:0]  FACTORY_READ     = 8'h00;

  // Prescaler figures: zero means full scale, and a final divide by two follows.
  localparam logic [8:0]  SCALE_FULL       = 9'h100;
  localparam logic [8:0]  SCALE_ONE        = 9'h001;
  localparam int unsigned SA_POST_DIVIDE   = 2;

endpackage

// File: hw/scale_a_if.sv
`timescale 1ns/1ns
interface scale_a_if;
  logic [7:0] scale_value;
  logic       scale_load;
  logic       scaled_clock_a;

  modport ctrl (output scale_value, output scale_load, input scaled_clock_a);
  modport pre  (input scale_value, input scale_load, output scaled_clock_a);
endinterface

// File: hw/scale_a_prescaler.sv
`timescale 1ns/1ns
module scale_a_prescaler (
  input  wire logic  clk,
  input  wire logic  reset,
  scale_a_if.pre     sa
);

  typedef struct packed {
    logic [8:0] cnt;
    logic       half;
    logic       tick;
  } pre_state_t;

  pre_state_t st;
  pre_state_t next_st;
  logic [8:0] eff_scale;

  // Zero stands for a full scale of 256.
  assign eff_scale = (sa.scale_value == 8'h00) ? pwm_scaler_pkg::SCALE_FULL : {1'b0, sa.scale_value};

  // Count clock A down through the scale, then halve with a toggle stage.
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (sa.scale_load) begin
      next_st.cnt  = eff_scale;
      next_st.half = 1'b0;
    end else if (st.cnt <= pwm_scaler_pkg::SCALE_ONE) begin
      next_st.cnt  = eff_scale;
      next_st.half = ~st.half;
      next_st.tick = st.half;
    end else begin
      next_st.cnt = st.cnt - 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{cnt: pwm_scaler_pkg::SCALE_FULL, half: 1'b0, tick: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sa.scaled_clock_a = st.tick;

  // Helper: cycles since the last tick, and whether a reload disturbed that span.
  // Eleven bits so that the full-scale span of 512 cycles does not wrap to zero.
  logic [10:0] gap;
  logic        clean;
  always_ff @(posedge clk) begin
    if (reset || sa.scale_load) begin
      gap   <= 11'h000;
      clean <= 1'b0;
    end else if (st.tick) begin
      gap   <= 11'h001;
      clean <= 1'b1;
    end else begin
      gap   <= gap + 11'h001;
    end
  end

  a_sa_period_exact: assert property (@(posedge clk) disable iff (reset)
    (st.tick && clean && !$past(sa.scale_load)) |-> (gap == 11'(eff_scale) * 11'(pwm_scaler_pkg::SA_POST_DIVIDE)))
    else $error("Scaled clock A period differs from twice the scale.");

  a_scale_reload: assert property (@(posedge clk) disable iff (reset)
    sa.scale_load |=> (st.cnt == $past(eff_scale)) && !st.half)
    else $error("Scale counter did not reload after a scale write.");

  a_zero_full: assert property (@(posedge clk) disable iff (reset)
    (sa.scale_load && sa.scale_value == 8'h00) |=> st.cnt == 9'h100)
    else $error("Zero scale was not taken as full scale.");

endmodule

// File: hw/pwm_channel_scaler.sv
`timescale 1ns/1ns
module pwm_channel_scaler (
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            PWM_OUT
);

  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       clk_sel;
    logic       run;
    logic [7:0] scale;
    logic [7:0] period_buf;
    logic [7:0] duty_buf;
    logic [7:0] period_act;
    logic [7:0] duty_act;
    logic [7:0] cnt;
    logic       phase;
    logic       pwm_out;
    logic [7:0] rdata;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;

  scale_a_if sa ();

  scale_a_prescaler u_prescaler (
    .clk   (REF_CLK),
    .reset (RESET),
    .sa    (sa)
  );

  logic       wr_ctl;
  logic       wr_cnt;
  logic       wr_per;
  logic       wr_duty;
  logic       src_tick;
  logic       period_end;
  logic [7:0] cnt_inc;

  // Decode of the register port; the factory test address has no write effect.
  assign wr_ctl      = WR && (ADDR == pwm_scaler_pkg::ADDR_CONTROL);
  assign wr_cnt      = WR && (ADDR == pwm_scaler_pkg::ADDR_COUNTER);
  assign wr_per      = WR && (ADDR == pwm_scaler_pkg::ADDR_PERIOD);
  assign wr_duty     = WR && (ADDR == pwm_scaler_pkg::ADDR_DUTY);
  assign sa.scale_load  = WR && (ADDR == pwm_scaler_pkg::ADDR_SCALE_A);
  assign sa.scale_value = next_st.scale;

  // Clock A is the register clock itself, so it ticks every cycle.
  assign src_tick   = st.clk_sel ? sa.scaled_clock_a : 1'b1;
  assign period_end = (st.period_act == 8'h00) || (st.cnt >= st.period_act - 8'h01);
  assign cnt_inc    = st.cnt + 8'h01;

  // Next-state logic for the channel and its register file.
  always_comb begin
    next_st = st;

    // Software register writes.
    if (wr_ctl) begin
      next_st.enable   = WDATA[pwm_scaler_pkg::CTL_ENABLE_BIT];
      next_st.polarity = WDATA[pwm_scaler_pkg::CTL_POLARITY_BIT];
      next_st.clk_sel  = WDATA[pwm_scaler_pkg::CTL_CLKSEL_BIT];
    end
    if (sa.scale_load) begin
      next_st.scale = WDATA;
    end
    if (wr_per) begin
      next_st.period_buf = WDATA;
      if (!st.run) begin
        next_st.period_act = WDATA;
      end
    end
    if (wr_duty) begin
      next_st.duty_buf = WDATA;
      if (!st.run) begin
        next_st.duty_act = WDATA;
      end
    end

    // The gate follows the enable bit only on a source edge, so the counter
    // never sees a partial clock period.
    if (src_tick) begin
      next_st.run = st.enable;
    end

    if (wr_cnt) begin
      // A counter write restarts the cycle with the buffered values.
      next_st.cnt        = 8'h00;
      next_st.phase      = 1'b0;
      next_st.period_act = next_st.period_buf;
      next_st.duty_act   = next_st.duty_buf;
    end else if (st.run && !next_st.run) begin
      // Disabling the channel hands pending values over to the active latches.
      next_st.period_act = next_st.period_buf;
      next_st.duty_act   = next_st.duty_buf;
    end else if (st.run && src_tick) begin
      if (period_end) begin
        next_st.cnt        = 8'h00;
        next_st.phase      = 1'b0;
        next_st.period_act = next_st.period_buf;
        next_st.duty_act   = next_st.duty_buf;
      end else begin
        next_st.cnt = cnt_inc;
        if (cnt_inc == st.duty_act) begin
          next_st.phase = ~st.phase;
        end
      end
    end
    // Without a running gate the counter keeps its value unless a counter write clears it.

    // The output flop stays registered; polarity picks true or inverted phase.
    next_st.pwm_out = next_st.polarity ? ~next_st.phase : next_st.phase;

    // Read data stand for one cycle after the strobe, zero otherwise.
    next_st.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        pwm_scaler_pkg::ADDR_CONTROL: begin
          next_st.rdata = {5'h00, st.clk_sel, st.polarity, st.enable};
        end
        pwm_scaler_pkg::ADDR_COUNTER: begin
          next_st.rdata = st.cnt;
        end
        pwm_scaler_pkg::ADDR_PERIOD: begin
          next_st.rdata = st.period_buf;
        end
        pwm_scaler_pkg::ADDR_DUTY: begin
          next_st.rdata = st.duty_buf;
        end
        pwm_scaler_pkg::ADDR_FACTORY: begin
          next_st.rdata = pwm_scaler_pkg::FACTORY_READ;
        end
        pwm_scaler_pkg::ADDR_SCALE_A: begin
          next_st.rdata = st.scale;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st <= '{enable:     pwm_scaler_pkg::CONTROL_RESET[pwm_scaler_pkg::CTL_ENABLE_BIT],
              polarity:   pwm_scaler_pkg::CONTROL_RESET[pwm_scaler_pkg::CTL_POLARITY_BIT],
              clk_sel:    pwm_scaler_pkg::CONTROL_RESET[pwm_scaler_pkg::CTL_CLKSEL_BIT],
              run:        1'b0,
              scale:      pwm_scaler_pkg::SCALE_RESET,
              period_buf: pwm_scaler_pkg::PERIOD_RESET,
              duty_buf:   pwm_scaler_pkg::DUTY_RESET,
              period_act: pwm_scaler_pkg::PERIOD_RESET,
              duty_act:   pwm_scaler_pkg::DUTY_RESET,
              cnt:        8'h00,
              phase:      1'b0,
              pwm_out:    1'b0,
              rdata:      8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign RDATA   = st.rdata;
  assign PWM_OUT = st.pwm_out;

  // Sequences shared by the checks below.
  sequence s_counter_write;
    WR && (ADDR == pwm_scaler_pkg::ADDR_COUNTER);
  endsequence

  sequence s_counter_cleared;
    (st.cnt == 8'h00) && !st.phase;
  endsequence

  sequence s_factory_read;
    RD && (ADDR == pwm_scaler_pkg::ADDR_FACTORY);
  endsequence

  a_factory_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_factory_read |=> (RDATA == 8'h00))
    else $error("Factory test register did not read zero.");

  a_counter_write: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_counter_write |=> s_counter_cleared ##0 (st.period_act == $past(next_st.period_buf)))
    else $error("Counter write did not clear and latch.");

  a_hold_disabled: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!st.run && !wr_cnt) |=> $stable(st.cnt))
    else $error("Disabled counter moved.");

  a_gate_on_edge: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run != $past(st.run)) |-> $past(src_tick))
    else $error("Counter gate changed without a source edge.");

  a_period_wrap: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && src_tick && !wr_cnt && st.enable && period_end) |=> s_counter_cleared)
    else $error("Counter did not wrap at the active period.");

  a_start_level: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.cnt == 8'h00 && !st.phase) |-> (PWM_OUT == st.polarity))
    else $error("Output did not start at its polarity level.");

  a_buffer_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && next_st.run && !wr_cnt && !(src_tick && period_end)) |=> $stable(st.period_act) && $stable(st.duty_act))
    else $error("Active values changed mid-cycle while enabled.");

  a_direct_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
    (wr_per && !st.run && !wr_cnt) |=> (st.period_act == $past(WDATA)))
    else $error("Disabled period write missed the active latch.");

  a_duty_toggle: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && src_tick && !wr_cnt && st.enable && !period_end && cnt_inc == st.duty_act) |=> (st.phase != $past(st.phase)))
    else $error("Output did not toggle at duty match.");

  a_counter_read: assert property (@(posedge REF_CLK) disable iff (RESET)
    (RD && ADDR == pwm_scaler_pkg::ADDR_COUNTER) |=> (RDATA == $past(st.cnt)))
    else $error("Counter read returned a wrong value.");

  // Further checks on the register port and the channel datapath.
  // They guard paths that the waveform measurements alone would not pin down.

  // Read data must fall back to zero when no read was asked for.
  a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
    !RD |=> (RDATA == 8'h00))
    else $error("Read data stood without a read strobe.");

  // The prescaler must see the value being written, not the old one.
  a_scale_forward: assert property (@(posedge REF_CLK) disable iff (RESET)
    sa.scale_load |-> (sa.scale_value == WDATA))
    else $error("Prescaler did not see the written scale.");

  // Falling gate hands pending values over, so no stale waveform survives a restart.
  a_disable_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && !next_st.run && !wr_cnt) |=> (st.period_act == $past(next_st.period_buf)))
    else $error("Disable did not latch the buffered period.");

  // Wrap latches duty too; a missed duty latch would mix old and new waveforms.
  a_wrap_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && src_tick && !wr_cnt && st.enable && period_end) |=> (st.duty_act == $past(next_st.duty_buf)))
    else $error("Period end did not latch the buffered duty.");

  // A running, still enabled counter steps by exactly one per source tick before the period end.
  a_count_step: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st.run && src_tick && !wr_cnt && st.enable && !period_end) |=> (st.cnt == $past(st.cnt) + 8'h01))
    else $error("Counter did not step by one.");

  // A stopped channel must not toggle its output phase either.
  a_phase_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!st.run && !wr_cnt) |=> $stable(st.phase))
    else $error("Disabled channel changed its phase.");

  // The pin is the phase passed through the polarity mux.
  a_polarity_out: assert property (@(posedge REF_CLK) disable iff (RESET)
    PWM_OUT == (st.polarity ^ st.phase))
    else $error("Output does not follow polarity and phase.");

  // Duty written while stopped reaches the active latch at once.
  a_direct_duty: assert property (@(posedge REF_CLK) disable iff (RESET)
    (wr_duty && !st.run && !wr_cnt) |=> (st.duty_act == $past(WDATA)))
    else $error("Disabled duty write missed the active latch.");

  // Writes to the factory test address must leave the scale, period buffer and enable bit alone.
  a_factory_nowrite: assert property (@(posedge REF_CLK) disable iff (RESET)
    (WR && ADDR == pwm_scaler_pkg::ADDR_FACTORY) |=> $stable(st.scale) && $stable(st.period_buf) && $stable(st.enable))
    else $error("Factory test write changed a register.");

  // The gate may only rise on a source tick, so the first cycle starts cleanly.
  a_gate_rise: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!st.run && next_st.run) |-> src_tick)
    else $error("Counter gate rose without a source edge.");

endmodule

// File: dv/pwm_load_model.sv
`timescale 1ns/1ns
// Load on the modulated pin: measures the latest complete high time and period in clock cycles.
module pwm_load_model (
  input  wire logic        clk,
  input  wire logic        pin,
  output logic      [15:0] high_time,
  output logic      [15:0] period_time
);
  logic        last_pin;
  logic [15:0] high_run;
  logic [15:0] since_rise;

  // Only finished pulses are published, so a half-seen pulse never reaches a compare.
  always_ff @(posedge clk) begin
    last_pin   <= pin;
    high_run   <= pin ? high_run + 16'h0001 : 16'h0000;
    since_rise <= (pin && !last_pin) ? 16'h0001 : since_rise + 16'h0001;
    if (!pin && last_pin) begin
      high_time <= high_run;
    end
    if (pin && !last_pin) begin
      period_time <= since_rise;
    end
  end
endmodule

// File: dv/pwm_channel_scaler_bench.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module pwm_channel_scaler_bench;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        rd_seen = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [7:0]  wdata   = 8'h00;
  logic [7:0]  rdata;
  logic        pwm_out;
  logic [15:0] high_time;
  logic [15:0] period_time;
  logic [7:0]  exp_v;
  logic [7:0]  p;
  logic [7:0]  d;
  logic [7:0]  s;
  logic [7:0]  expect_q[$];
  int          num_errors   = 0;
  int          total_checks = 0;

  pwm_channel_scaler pwm_channel_scaler_inst (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PWM_OUT(pwm_out));
  pwm_load_model pwm_load_model_inst (.clk(ref_clk), .pin(pwm_out), .high_time(high_time),
    .period_time(period_time));

  // Half period of 50 ns gives the 10 MHz reference clock.
  always #50 ref_clk = ~ref_clk;

  // Read data stand only in the cycle after the strobe, so they are compared mid-way through it.
  always @(posedge ref_clk) rd_seen <= rd;
  always @(negedge ref_clk) begin
    if (rd_seen) begin
      exp_v = expect_q.pop_front();
      `CHECK(rdata, exp_v)
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    rd    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    wr   <= 1'b0;
    expect_q.push_back(v);
  endtask

  task automatic idle(input int n);
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  // Stops the channel first so period and duty land in the active latches, then lets it settle.
  task automatic run_pwm(input logic [7:0] ctl, input logic [7:0] per, input logic [7:0] duty,
                         input logic [7:0] scale, input logic [15:0] eh, input logic [15:0] ep);
    wr_reg(pwm_scaler_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(pwm_scaler_pkg::ADDR_SCALE_A, scale);
    wr_reg(pwm_scaler_pkg::ADDR_PERIOD, per);
    wr_reg(pwm_scaler_pkg::ADDR_DUTY, duty);
    wr_reg(pwm_scaler_pkg::ADDR_CONTROL, ctl);
    idle(4 * int'(ep) + 40);
    `CHECK(high_time, eh)
    `CHECK(period_time, ep)
  endtask

  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog sits far beyond the roughly five thousand cycles the sequence needs.
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h7F33));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    idle(1);
    rd_reg(pwm_scaler_pkg::ADDR_CONTROL, 8'h00);
    rd_reg(pwm_scaler_pkg::ADDR_PERIOD, 8'h00);
    rd_reg(pwm_scaler_pkg::ADDR_SCALE_A, 8'h00);
    rd_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h00);
    wr_reg(pwm_scaler_pkg::ADDR_FACTORY, 8'h5A);
    rd_reg(pwm_scaler_pkg::ADDR_FACTORY, 8'h00);
    rd_reg(4'hF, 8'h00);
    idle(1);
    run_pwm(8'h03, 8'h04, 8'h01, 8'h00, 16'h0001, 16'h0004);
    wr_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h77);
    rd_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h00);
    rd_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h01);
    rd_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h02);
    wr_reg(pwm_scaler_pkg::ADDR_DUTY, 8'h03);
    rd_reg(pwm_scaler_pkg::ADDR_DUTY, 8'h03);
    idle(30);
    `CHECK(high_time, 16'h0003)
    wr_reg(pwm_scaler_pkg::ADDR_CONTROL, 8'h00);
    idle(3);
    wr_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h00);
    idle(12);
    rd_reg(pwm_scaler_pkg::ADDR_COUNTER, 8'h00);
    idle(1);
    repeat (4) begin
      p = 8'($urandom_range(9, 2));
      d = 8'($urandom_range(int'(p) - 1, 1));
      run_pwm(8'h01, p, d, 8'h00, 16'(p - d), 16'(p));
      run_pwm(8'h03, p, d, 8'h00, 16'(d), 16'(p));
    end
    s = 8'($urandom_range(6, 1));
    run_pwm(8'h07, 8'h02, 8'h01, s, 16'(2 * s), 16'(4 * s));
    rd_reg(pwm_scaler_pkg::ADDR_SCALE_A, s);
    idle(1);
    run_pwm(8'h07, 8'h02, 8'h01, 8'h00, 16'd512, 16'd1024);
    idle(2);
    complete_run();
  end
endmodule
